// [hdl/rmr_pkg.sv]
// rmr_pkg: shared constants and carriers for the port traffic mirror
// assumes: one clock domain, 32-bit classic wishbone register access
package rmr_pkg;
  // ----------------------------------------------------------------
  // port numbering and register map
  // ----------------------------------------------------------------
  localparam int          RMR_PW       = 3;          // port index width
  localparam logic [7:0]  RMR_A_CMD    = 8'h00;      // command, write only
  localparam logic [7:0]  RMR_A_STAT   = 8'h04;      // status, read only
  localparam logic [7:0]  RMR_A_MACLO  = 8'h08;      // analyzer mac [31:0]
  localparam logic [7:0]  RMR_A_MACHI  = 8'h0C;      // analyzer mac [47:32]
  localparam logic [7:0]  RMR_A_DROP   = 8'h10;      // dropped copy count
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int          RMR_F_OP     = 0;          // opcode [2:0]
  localparam int          RMR_F_ARG    = 8;          // port argument
  localparam int          RMR_F_DEF    = 0;          // stat: analyzer defined
  localparam int          RMR_F_ACT    = 1;          // stat: mirroring active
  localparam int          RMR_F_ERR    = 2;          // stat: last cmd refused
  localparam int          RMR_F_ANA    = 8;          // stat: analyzer port
  localparam int          RMR_F_MON    = 16;         // stat: monitored port
  localparam logic [15:0] RMR_DROP_RST = 16'h0000;
  localparam logic [47:0] RMR_MAC_RST  = 48'h0;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    RMR_OP_NOP   = 3'b000,
    RMR_OP_DEF   = 3'b001,
    RMR_OP_UNDEF = 3'b010,
    RMR_OP_START = 3'b011,
    RMR_OP_STOP  = 3'b100
  } rmr_op_t;

  // one beat seen on a switch receive or transmit path
  typedef struct packed {
    logic              valid;
    logic [RMR_PW-1:0] port;
    logic [7:0]        data;
    logic              sof;
    logic              eof;
  } rmr_tap_t;

  // one beat sent to the analyzer port
  typedef struct packed {
    logic [7:0] data;
    logic       last;
    logic       err;
  } rmr_beat_t;
endpackage : rmr_pkg

// [hdl/rmr_rst_sync.sv]
// rmr_rst_sync: releases an active-low reset through two flops
// assumes: asynchronous assertion, release aligned to i_clk
`timescale 1ns/1ps
module rmr_rst_sync (
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  output logic      o_rst_n
);
  logic meta_r;

  // assert at once, release after two edges
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r  <= 1'b0;
      o_rst_n <= 1'b0;
    end else begin
      meta_r  <= 1'b1;
      o_rst_n <= meta_r;
    end
  end
endmodule : rmr_rst_sync

// [hdl/rmr_buf.sv]
// rmr_buf: two-entry buffer for mirrored beats, output from slot 0
// assumes: push only while o_in_rdy, consumer may stall freely
`timescale 1ns/1ps
module rmr_buf (
  input  wire logic              i_clk,
  input  wire logic              i_rst_n,
  input  wire logic              i_in_vld,
  input  rmr_pkg::rmr_beat_t     i_in,
  output logic                   o_in_rdy,
  output logic                   o_out_vld,
  output rmr_pkg::rmr_beat_t     o_out,
  input  wire logic              i_out_rdy
);
  import rmr_pkg::*;
  logic      v1_r, v0_nxt, v1_nxt;
  rmr_beat_t d1_r, d0_nxt, d1_nxt;

  assign o_in_rdy = ~v1_r;  // full only when both slots hold data

  // shift toward slot 0, fill the first free slot
  always_comb begin
    v0_nxt = o_out_vld;
    v1_nxt = v1_r;
    d0_nxt = o_out;
    d1_nxt = d1_r;
    if (o_out_vld && i_out_rdy) begin
      v0_nxt = v1_r;
      d0_nxt = d1_r;
      v1_nxt = 1'b0;
    end
    if (i_in_vld && o_in_rdy) begin
      if (!v0_nxt) begin
        v0_nxt = 1'b1;
        d0_nxt = i_in;
      end else begin
        v1_nxt = 1'b1;
        d1_nxt = i_in;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_out_vld <= 1'b0;
      v1_r      <= 1'b0;
      o_out     <= '0;
      d1_r      <= '0;
    end else begin
      o_out_vld <= v0_nxt;
      v1_r      <= v1_nxt;
      o_out     <= d0_nxt;
      d1_r      <= d1_nxt;
    end
  end
endmodule : rmr_buf

// [hdl/rmr_mirror.sv]
// rmr_mirror: copies rx and tx traffic of one port to an analyzer port
// assumes: taps observe the switch paths without back-pressure;
// the switch core applies the block, stp and vlan controls it is given
`timescale 1ns/1ps
module rmr_mirror #(
  parameter int NPORT = 8
) (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst_n,
  input  wire logic                       i_wb_cyc,
  input  wire logic                       i_wb_stb,
  input  wire logic                       i_wb_we,
  input  wire logic [7:0]                 i_wb_adr,
  input  wire logic [3:0]                 i_wb_sel,
  input  wire logic [31:0]                i_wb_dat,
  output logic [31:0]                     o_wb_dat,
  output logic                            o_wb_ack,
  input  rmr_pkg::rmr_tap_t               i_rx_tap,
  input  rmr_pkg::rmr_tap_t               i_tx_tap,
  input  wire logic [NPORT-1:0]           i_stp_cfg,
  input  wire logic [NPORT-1:0]           i_trunk,
  output logic                            o_mir_vld,
  output rmr_pkg::rmr_beat_t              o_mir,
  input  wire logic                       i_mir_rdy,
  output logic [NPORT-1:0]                o_port_blk,
  output logic [NPORT-1:0]                o_stp_en,
  output logic                            o_vlan_drop,
  output logic                            o_vlan_dflt,
  output logic [rmr_pkg::RMR_PW-1:0]      o_vlan_port
);
  import rmr_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [NPORT-1:0] port_bit(input logic [RMR_PW-1:0] p);
    port_bit = '0;
    port_bit[p] = 1'b1;
  endfunction : port_bit
  typedef enum logic [1:0] {
    RMR_S_IDLE = 2'b00,
    RMR_S_RX   = 2'b01,
    RMR_S_TX   = 2'b10,
    RMR_S_END  = 2'b11
  } rmr_sel_t;
  logic              rst_n;
  logic              ack_nxt;
  logic [31:0]       rd_nxt;
  logic              wr, cmd;
  rmr_op_t           op;
  logic [RMR_PW-1:0] arg;
  logic              def_r, def_nxt, act_r, act_nxt, err_r, err_nxt;
  logic [RMR_PW-1:0] ana_r, ana_nxt, mon_r, mon_nxt;
  logic [47:0]       mac_r, mac_nxt;
  logic [15:0]       drop_r, drop_nxt;
  logic [NPORT-1:0]  blk_nxt, stp_nxt;
  logic              vdrop_nxt, vdflt_nxt;
  logic [RMR_PW-1:0] vport_nxt;
  rmr_sel_t          sel_r, sel_nxt;
  logic              push, b_rdy, rx_hit, tx_hit;
  rmr_beat_t         pbeat;

  rmr_rst_sync u_rst (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .o_rst_n (rst_n)
  );

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  // write acts at the edge where the master sees ack
  assign wr  = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack;
  assign cmd = wr && (i_wb_adr == RMR_A_CMD) && i_wb_sel[0];
  assign op  = rmr_op_t'(i_wb_dat[RMR_F_OP +: 3]);
  assign arg = i_wb_dat[RMR_F_ARG +: RMR_PW];
  // one-cycle ack, read data captured with it
  always_comb begin
    ack_nxt = i_wb_cyc && i_wb_stb && !o_wb_ack;
    rd_nxt  = 32'h0;
    if (i_wb_adr == RMR_A_STAT) begin
      rd_nxt[RMR_F_DEF]            = def_r;
      rd_nxt[RMR_F_ACT]            = act_r;
      rd_nxt[RMR_F_ERR]            = err_r;
      rd_nxt[RMR_F_ANA +: RMR_PW]  = ana_r;
      rd_nxt[RMR_F_MON +: RMR_PW]  = mon_r;
    end else if (i_wb_adr == RMR_A_MACLO) begin
      rd_nxt = mac_r[31:0];
    end else if (i_wb_adr == RMR_A_MACHI) begin
      rd_nxt[15:0] = mac_r[47:32];
    end else if (i_wb_adr == RMR_A_DROP) begin
      rd_nxt[15:0] = drop_r;
    end
    if (!ack_nxt || i_wb_we) begin
      rd_nxt = 32'h0;
    end
  end

  // ----------------------------------------------------------------
  // configuration commands
  // ----------------------------------------------------------------
  always_comb begin
    def_nxt   = def_r;
    act_nxt   = act_r;
    err_nxt   = err_r;
    ana_nxt   = ana_r;
    mon_nxt   = mon_r;
    mac_nxt   = mac_r;
    vdrop_nxt = 1'b0;
    vdflt_nxt = 1'b0;
    vport_nxt = o_vlan_port;
    if (wr && i_wb_adr == RMR_A_MACLO) begin
      for (int b = 0; b < 4; b++) begin
        if (i_wb_sel[b]) begin
          mac_nxt[8*b +: 8] = i_wb_dat[8*b +: 8];
        end
      end
    end
    if (wr && i_wb_adr == RMR_A_MACHI) begin
      for (int b = 0; b < 2; b++) begin
        if (i_wb_sel[b]) begin
          mac_nxt[32+8*b +: 8] = i_wb_dat[8*b +: 8];
        end
      end
    end
    if (cmd) begin
      err_nxt = 1'b0;
      case (op)
        RMR_OP_DEF: begin
          if (def_r || int'(arg) >= NPORT) begin
            err_nxt = 1'b1;
          end else begin
            def_nxt   = 1'b1;
            ana_nxt   = arg;
            vdrop_nxt = 1'b1;
            vport_nxt = arg;
          end
        end
        RMR_OP_UNDEF: begin
          if (!def_r) begin
            err_nxt = 1'b1;
          end else begin
            def_nxt   = 1'b0;
            act_nxt   = 1'b0;
            vdflt_nxt = 1'b1;
            vport_nxt = ana_r;
          end
        end
        RMR_OP_START: begin
          if (!def_r || act_r || int'(arg) >= NPORT) begin
            err_nxt = 1'b1;
          end else if (arg == ana_r) begin
            err_nxt = 1'b1;
          end else if (i_trunk[arg]) begin
            err_nxt = 1'b1;
          end else begin
            act_nxt = 1'b1;
            mon_nxt = arg;
          end
        end
        RMR_OP_STOP: begin
          act_nxt = 1'b0;
        end
        default: begin
          err_nxt = 1'b1;
        end
      endcase
    end
    // port masks follow the analyzer designation
    blk_nxt = def_nxt ? port_bit(ana_nxt) : '0;
    stp_nxt = i_stp_cfg & ~blk_nxt;
  end

  // ----------------------------------------------------------------
  // copy path
  // ----------------------------------------------------------------
  assign rx_hit = i_rx_tap.valid && i_rx_tap.port == mon_r;
  assign tx_hit = i_tx_tap.valid && i_tx_tap.port == mon_r;
  // lock one source per frame so copies never interleave
  always_comb begin
    sel_nxt  = sel_r;
    drop_nxt = drop_r;
    push     = 1'b0;
    pbeat    = '0;
    case (sel_r)
      RMR_S_IDLE: begin
        if (act_r && rx_hit && i_rx_tap.sof) begin
          pbeat = '{data: i_rx_tap.data, last: i_rx_tap.eof, err: 1'b0};
          push  = b_rdy;
          if (!i_rx_tap.eof && b_rdy) begin
            sel_nxt = RMR_S_RX;
          end
        end else if (act_r && tx_hit && i_tx_tap.sof) begin
          pbeat = '{data: i_tx_tap.data, last: i_tx_tap.eof, err: 1'b0};
          push  = b_rdy;
          if (!i_tx_tap.eof && b_rdy) begin
            sel_nxt = RMR_S_TX;
          end
        end
      end
      RMR_S_RX: begin
        if (!act_r) begin
          sel_nxt = RMR_S_END;
        end else if (rx_hit) begin
          pbeat   = '{data: i_rx_tap.data, last: i_rx_tap.eof, err: 1'b0};
          push    = b_rdy;
          sel_nxt = !b_rdy ? RMR_S_END : i_rx_tap.eof ? RMR_S_IDLE : RMR_S_RX;
        end
      end
      RMR_S_TX: begin
        if (!act_r) begin
          sel_nxt = RMR_S_END;
        end else if (tx_hit) begin
          pbeat   = '{data: i_tx_tap.data, last: i_tx_tap.eof, err: 1'b0};
          push    = b_rdy;
          sel_nxt = !b_rdy ? RMR_S_END : i_tx_tap.eof ? RMR_S_IDLE : RMR_S_TX;
        end
      end
      RMR_S_END: begin
        // close a cut frame with an error beat
        pbeat = '{data: 8'h00, last: 1'b1, err: 1'b1};
        push  = b_rdy;
        if (b_rdy) begin
          sel_nxt = RMR_S_IDLE;
        end
      end
      default: begin
        sel_nxt = RMR_S_IDLE;
      end
    endcase
    // count frames lost: no room at sof, other source locked, or a cut frame closed
    if (act_r && rx_hit && i_rx_tap.sof && sel_r != RMR_S_RX && !(sel_r == RMR_S_IDLE && b_rdy)) begin
      drop_nxt = drop_nxt + 16'h0001;
    end
    if (act_r && tx_hit && i_tx_tap.sof && sel_r != RMR_S_TX
        && !(sel_r == RMR_S_IDLE && b_rdy && !(rx_hit && i_rx_tap.sof))) begin
      drop_nxt = drop_nxt + 16'h0001;             // rx wins a shared sof
    end
    if (sel_r == RMR_S_END && b_rdy) begin
      drop_nxt = drop_nxt + 16'h0001;             // counted even after stop
    end
  end

  rmr_buf u_buf (
    .i_clk     (i_clk),
    .i_rst_n   (rst_n),
    .i_in_vld  (push),
    .i_in      (pbeat),
    .o_in_rdy  (b_rdy),
    .o_out_vld (o_mir_vld),
    .o_out     (o_mir),
    .i_out_rdy (i_mir_rdy)
  );

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_wb_ack    <= 1'b0;
      o_wb_dat    <= 32'h0;
      def_r       <= 1'b0;
      act_r       <= 1'b0;
      err_r       <= 1'b0;
      ana_r       <= '0;
      mon_r       <= '0;
      mac_r       <= RMR_MAC_RST;
      drop_r      <= RMR_DROP_RST;
      sel_r       <= RMR_S_IDLE;
      o_port_blk  <= '0;
      o_stp_en    <= '0;
      o_vlan_drop <= 1'b0;
      o_vlan_dflt <= 1'b0;
      o_vlan_port <= '0;
    end else begin
      o_wb_ack    <= ack_nxt;
      o_wb_dat    <= rd_nxt;
      def_r       <= def_nxt;
      act_r       <= act_nxt;
      err_r       <= err_nxt;
      ana_r       <= ana_nxt;
      mon_r       <= mon_nxt;
      mac_r       <= mac_nxt;
      drop_r      <= drop_nxt;
      sel_r       <= sel_nxt;
      o_port_blk  <= blk_nxt;
      o_stp_en    <= stp_nxt;
      o_vlan_drop <= vdrop_nxt;
      o_vlan_dflt <= vdflt_nxt;
      o_vlan_port <= vport_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);
  property p_copy; act_r && sel_r == RMR_S_IDLE && rx_hit && i_rx_tap.sof && b_rdy |=> o_mir_vld; endproperty
  a_copy: assert property (p_copy) else $error("copy not emitted");
  property p_one; $onehot0(o_port_blk); endproperty
  a_one: assert property (p_one) else $error("more than one analyzer");
  property p_blk; def_r |-> o_port_blk[ana_r]; endproperty
  a_blk: assert property (p_blk) else $error("analyzer not blocked");
  property p_same; act_r |-> mon_r != ana_r; endproperty
  a_same: assert property (p_same) else $error("monitor equals analyzer");
  property p_stp; (o_stp_en & o_port_blk) == '0; endproperty
  a_stp: assert property (p_stp) else $error("stp on analyzer");
  property p_rest; $fell(def_r) |-> o_stp_en == $past(i_stp_cfg); endproperty
  a_rest: assert property (p_rest) else $error("stp not restored");
  property p_vdrop; $rose(def_r) |-> o_vlan_drop && o_vlan_port == ana_r; endproperty
  a_vdrop: assert property (p_vdrop) else $error("vlan drop missing");
  property p_vdflt; $fell(def_r) |-> o_vlan_dflt ##1 !o_vlan_dflt; endproperty
  a_vdflt: assert property (p_vdflt) else $error("default vlan missing");
  property p_trunk; cmd && op == RMR_OP_START && i_trunk[arg] |=> err_r && !$rose(act_r); endproperty
  a_trunk: assert property (p_trunk) else $error("trunk accepted");
  property p_ack; i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack; endproperty
  a_ack: assert property (p_ack) else $error("ack late");
  property p_hold; o_mir_vld && !i_mir_rdy |=> o_mir_vld && $stable(o_mir); endproperty
  a_hold: assert property (p_hold) else $error("stalled beat changed");
  c_start: cover property ($rose(act_r));
  c_frame: cover property (o_mir_vld && i_mir_rdy && o_mir.last && !o_mir.err);
  c_cut:   cover property (sel_r == RMR_S_END && b_rdy);
  c_undef: cover property ($fell(def_r));
endmodule : rmr_mirror

// [dv/rmr_sink.sv]
// rmr_sink: analyzer probe model, collects mirrored beats
// assumes: a beat is taken at a rising edge with vld and rdy high
`timescale 1ns/1ps
module rmr_sink (
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_stall,
  input  wire logic          i_vld,
  input  rmr_pkg::rmr_beat_t i_beat,
  output logic               o_rdy
);
  import rmr_pkg::*;
  rmr_beat_t got[$];
  // keep each taken beat, ready follows the stall request
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdy <= 1'b0;
    end else begin
      if (i_vld && o_rdy) got.push_back(i_beat);
      o_rdy <= !i_stall;
    end
  end
endmodule : rmr_sink

// [dv/port_traffic_mirroring_tb.sv]
// port_traffic_mirroring_tb: self-checking bench for rmr_mirror
// assumes: wishbone answers by ack, rmr_sink stands as analyzer
`timescale 1ns/1ps
module port_traffic_mirroring_tb;
  import rmr_pkg::*;
  logic        i_clk = 1'b0, i_rst_n = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, stall = 1'b0;
  logic [7:0]  adr = 8'h00, stp = 8'h5E, trk = 8'h40;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic        ack, mvld, mrdy, vdrop, vdflt;
  logic [7:0]  blk, stpen;
  logic [2:0]  vport, vp;
  rmr_tap_t    rx = '0, tx = '0;
  rmr_beat_t   mir, exp[$];
  int          n_mismatch = 0, samples_checked = 0, cycles = 0, n_vdrop = 0, n_vdflt = 0;

  always #25 i_clk = ~i_clk;

  rmr_mirror #(.NPORT(8)) dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
    .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack),
    .i_rx_tap(rx), .i_tx_tap(tx), .i_stp_cfg(stp), .i_trunk(trk), .o_mir_vld(mvld), .o_mir(mir),
    .i_mir_rdy(mrdy), .o_port_blk(blk), .o_stp_en(stpen), .o_vlan_drop(vdrop),
    .o_vlan_dflt(vdflt), .o_vlan_port(vport));
  rmr_sink sink_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_stall(stall), .i_vld(mvld), .i_beat(mir),
    .o_rdy(mrdy));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // count vlan pulses, timeout
  always @(posedge i_clk) begin
    cycles++;
    if (vdrop === 1'b1) n_vdrop++;
    if (vdflt === 1'b1) n_vdflt++;
    if (vdrop === 1'b1 || vdflt === 1'b1) vp = vport;
    if (cycles == 20000) begin
      n_mismatch++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one classic cycle, held until ack; only the bench timeout ends the wait
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hF;
    do begin
      @(posedge i_clk);
    end while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb

  task automatic cmd(input rmr_op_t op, input logic [2:0] p);
    wb(1'b1, RMR_A_CMD, {21'h0, p, 5'h0, op});
  endtask : cmd

  function automatic logic [31:0] st(logic [2:0] m, logic [2:0] a, logic e, logic c, logic d);
    return {13'h0, m, 5'h0, a, 5'h0, e, c, d};
  endfunction : st

  // drive a frame on one tap, optionally expect its copy
  task automatic tap(input logic t, input logic [2:0] p, input int n, input logic [7:0] b,
                     input logic ex);
    rmr_tap_t v;
    for (int i = 0; i < n; i++) begin
      @(posedge i_clk);
      v = '{1'b1, p, b + 8'(i), i == 0, i == n - 1};
      if (t) tx <= v;
      else rx <= v;
      if (ex) exp.push_back('{b + 8'(i), i == n - 1, 1'b0});
    end
    @(posedge i_clk);
    rx <= '0;
    tx <= '0;
  endtask : tap

  task automatic drain(input string nm);
    repeat (40) @(posedge i_clk);
    chk({nm, " count"}, 32'(exp.size()), 32'(sink_u.got.size()));
    foreach (exp[i]) if (i < sink_u.got.size()) chk(nm, 32'(exp[i]), 32'(sink_u.got[i]));
    exp.delete();
    sink_u.got.delete();
  endtask : drain

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    chk("blk", 0, 32'(blk));
    wb(1'b0, RMR_A_STAT, 0);
    chk("stat", 0, q); // idle report
    wb(1'b0, 8'h20, 0);
    chk("unmapped", 0, q);
    wb(1'b1, RMR_A_CMD, 32'h0000_0007);
    wb(1'b0, RMR_A_STAT, 0);
    chk("stat badop", st(0, 0, 1, 0, 0), q); // unknown op refused
  endtask : t_reset

  task automatic t_define();
    cmd(RMR_OP_DEF, 3'h2); // define first
    wb(1'b0, RMR_A_STAT, 0);
    chk("stat def", st(0, 2, 0, 0, 1), q);
    chk("blk", 32'h04, 32'(blk)); // analyzer blocked
    chk("stp", 32'h5A, 32'(stpen)); // forced off
    chk("vdrop", 1, n_vdrop);
    chk("vport", 2, 32'(vp));
    cmd(RMR_OP_DEF, 3'h3);
    wb(1'b0, RMR_A_STAT, 0);
    chk("stat def2", st(0, 2, 1, 0, 1), q); // second analyzer
  endtask : t_define

  task automatic t_start();
    cmd(RMR_OP_START, 3'h2);
    wb(1'b0, RMR_A_STAT, 0);
    chk("stat same", st(0, 2, 1, 0, 1), q);
    cmd(RMR_OP_START, 3'h6);
    wb(1'b0, RMR_A_STAT, 0);
    chk("stat trunk", st(0, 2, 1, 0, 1), q);
    wb(1'b1, RMR_A_MACLO, 32'h1234_5678);
    wb(1'b1, RMR_A_MACHI, 32'h0000_9ABC);
    cmd(RMR_OP_START, 3'h5);
    wb(1'b0, RMR_A_STAT, 0);
    chk("stat start", st(5, 2, 0, 1, 1), q);
    wb(1'b0, RMR_A_MACLO, 0);
    chk("maclo", 32'h1234_5678, q);
    wb(1'b0, RMR_A_MACHI, 0);
    chk("machi", 32'h0000_9ABC, q);
  endtask : t_start

  task automatic t_mirror();
    tap(1'b0, 3'h5, 4, 8'h10, 1'b1); // received copy
    tap(1'b1, 3'h5, 3, 8'hA0, 1'b1); // sent copy
    tap(1'b0, 3'h3, 4, 8'h30, 1'b0); // other port not copied
    tap(1'b1, 3'h5, 1, 8'hC0, 1'b1); // single beat frame
    drain("copy"); // order and content
  endtask : t_mirror

  task automatic t_stall();
    stall <= 1'b1;
    tap(1'b0, 3'h5, 6, 8'h40, 1'b0); // cut by a full buffer
    repeat (4) @(posedge i_clk);
    stall <= 1'b0;
    repeat (30) @(posedge i_clk);
    chk("first", 32'h100, 32'(sink_u.got[0]));
    chk("close", 32'h003, 32'(sink_u.got[$])); // error close
    sink_u.got.delete();
    wb(1'b0, RMR_A_DROP, 0);
    chk("drop", 1, q);
    tap(1'b1, 3'h5, 2, 8'h70, 1'b1);
    drain("after");
    // rx and tx frames start together: rx copied, tx dropped
    @(posedge i_clk);
    rx <= '{1'b1, 3'h5, 8'h90, 1'b1, 1'b1};
    tx <= '{1'b1, 3'h5, 8'h91, 1'b1, 1'b1};
    exp.push_back('{8'h90, 1'b1, 1'b0});
    @(posedge i_clk);
    rx <= '0;
    tx <= '0;
    drain("both"); // rx wins
    wb(1'b0, RMR_A_DROP, 0);
    chk("drop both", 2, q);
  endtask : t_stall

  task automatic t_stop();
    fork
      tap(1'b0, 3'h5, 8, 8'hB0, 1'b0); // frame cut by stop
      begin
        repeat (3) @(posedge i_clk);
        cmd(RMR_OP_STOP, 3'h0);
      end
    join
    repeat (20) @(posedge i_clk);
    chk("cut first", 32'h2C0, 32'(sink_u.got[0]));
    chk("cut close", 32'h003, 32'(sink_u.got[$])); // error close
    sink_u.got.delete();
    wb(1'b0, RMR_A_DROP, 0);
    chk("drop cut", 3, q);
    wb(1'b0, RMR_A_STAT, 0);
    chk("active", 0, 32'(q[1]));
    tap(1'b0, 3'h5, 3, 8'h80, 1'b0);
    drain("stopped");
    cmd(RMR_OP_UNDEF, 3'h0);
    wb(1'b0, RMR_A_STAT, 0);
    chk("defined", 0, 32'(q[0]));
    chk("blk", 0, 32'(blk));
    chk("stp", 32'h5E, 32'(stpen)); // restored
    chk("vdflt", 1, n_vdflt);
    chk("vport", 2, 32'(vp));
  endtask : t_stop

  task automatic results();
    if (n_mismatch == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    i_rst_n <= 1'b1;
    repeat (4) @(posedge i_clk);
    t_reset();
    t_define();
    t_start();
    t_mirror();
    t_stall();
    t_stop();
    results();
  end
endmodule : port_traffic_mirroring_tb
